// >>> core/dpm_consts.vh
// Constants for the debug port mode switch block
`ifndef DPM_CONSTS_VH
`define DPM_CONSTS_VH

// Register byte offsets on the peripheral bus
`define DPM_OFF_AFSEL      12'h000
`define DPM_OFF_DEN        12'h004
`define DPM_OFF_PUR        12'h008
`define DPM_OFF_LOCK       12'h00c
`define DPM_OFF_COMMIT     12'h010
`define DPM_OFF_STATUS     12'h014

// Pin bit positions inside the five-bit pin fields
`define DPM_PIN_TCK        0
`define DPM_PIN_TMS        1
`define DPM_PIN_TDI        2
`define DPM_PIN_TDO        3
`define DPM_PIN_TRST       4

// Reset values of the pin configuration fields, and the protection mask
`define DPM_AFSEL_RST      5'h1f
`define DPM_DEN_RST        5'h1f
`define DPM_PUR_RST        5'h1f
`define DPM_COMMIT_RST     5'h00
`define DPM_PROT_MASK      5'h1f

// Instruction codes
`define DPM_IR_EXTEST      4'h0
`define DPM_IR_INTEST      4'h1
`define DPM_IR_IDCODE      4'he
`define DPM_IR_BYPASS      4'hf
`define DPM_IR_CAPTURE     4'h1

// Mode switch patterns, run lengths counted in test clock edges, and the recovery switch count
`define DPM_PAT_TO_SWD     16'he79e
`define DPM_PAT_TO_JTAG    16'he73c
`define DPM_RUN_MIN        6'h32
`define DPM_PAT_LAST       5'h0f
`define DPM_RECOVER_COUNT  4'ha

`endif

// >>> core/dpm_debug_port.v
// Debug port: test access controller, shift chains, mode switch, recovery and pin configuration
// Notes on behaviour
// - Capture state loads the selected chain; shift states move it out TDO, in TDI.
// - Update state copies the shifted bits into the chain's parallel holding register.
// - After power-on or external reset the five debug pins default to debug function.
// - Writing zeros to the pins' alternate-function bits releases them to general I/O.
// - Protected alternate-function writes land only when unlocked and commit bit is one.
// - Ten alternating switch sequences under held external reset request a flash mass erase.
// - The fixed idle/select/reset state path from reset enables serial-wire, disables boundary-test.
// - Fifty ones reset both sides; in serial-wire mode they give a line reset.
// - In boundary-test mode five trailing ones leave the controller in Test-Logic-Reset.
// - Released pins other than TDI carry debug traffic again only after their select bits are set.
// - Instruction and data chains are reached only serially, never over the bus.
// - Five ones drive Test-Logic-Reset; the next rise spent there loads the identification instruction.
`timescale 1ns/1ps
`include "dpm_consts.vh"

module dpm_debug_port
#(
	parameter [31:0] IDCODE_VALUE = 32'h0000_1001, // Arbitrary identification value
	parameter [31:0] LOCK_KEY     = 32'h6b1d_52a7  // Arbitrary unlock key
)
(
	input  wire        pclk,
	input  wire        presetn,
	input  wire [11:0] paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        ext_rst_n,
	input  wire        tck,
	input  wire        tms,
	input  wire        tdi,
	input  wire        trst_n,
	output wire        tdo,
	output wire        tdo_oe,
	input  wire [31:0] dr_capture_data,
	output wire [31:0] dr_update_data,
	output wire        dr_update_strobe,
	output wire [3:0]  ir_current,
	output wire        swd_mode,
	output wire        swd_line_reset,
	output wire        mass_erase_req,
	output wire [4:0]  pin_digital_enable,
	output wire [4:0]  pin_pullup_enable,
	output wire [4:0]  pin_alternate_function_select
);

	// One-hot controller states
	localparam [15:0] S_TLR  = 16'h0001;
	localparam [15:0] S_RTI  = 16'h0002;
	localparam [15:0] S_SDR  = 16'h0004;
	localparam [15:0] S_CDR  = 16'h0008;
	localparam [15:0] S_SHDR = 16'h0010;
	localparam [15:0] S_E1DR = 16'h0020;
	localparam [15:0] S_PDR  = 16'h0040;
	localparam [15:0] S_E2DR = 16'h0080;
	localparam [15:0] S_UDR  = 16'h0100;
	localparam [15:0] S_SIR  = 16'h0200;
	localparam [15:0] S_CIR  = 16'h0400;
	localparam [15:0] S_SHIR = 16'h0800;
	localparam [15:0] S_E1IR = 16'h1000;
	localparam [15:0] S_PIR  = 16'h2000;
	localparam [15:0] S_E2IR = 16'h4000;
	localparam [15:0] S_UIR  = 16'h8000;

	// Chain kinds selected by the instruction
	localparam [1:0] K_BYP  = 2'h0;
	localparam [1:0] K_ID   = 2'h1;
	localparam [1:0] K_DATA = 2'h2;
	localparam [1:0] K_HOLD = 2'h3;

	reg  [4:0]  sync1_reg;
	reg  [4:0]  sync2_reg;
	reg         tck_prev_reg;
	reg         ext_prev_reg;
	reg  [4:0]  afsel_reg;
	reg  [4:0]  den_reg;
	reg  [4:0]  pur_reg;
	reg  [4:0]  commit_reg;
	reg         locked_reg;
	reg  [31:0] prdata_reg;
	reg  [5:0]  run_reg;
	reg  [4:0]  coll_reg;
	reg  [15:0] pat_reg;
	reg         long_reg;
	reg         swd_reg;
	reg         line_rst_reg;
	reg  [3:0]  rec_cnt_reg;
	reg         erase_reg;
	reg  [15:0] tap_reg;
	reg  [15:0] tap_next;
	reg  [3:0]  ir_shift_reg;
	reg  [3:0]  ir_reg;
	reg         byp_reg;
	reg  [31:0] dr_shift_reg;
	reg  [31:0] dr_upd_reg;
	reg         dr_stb_reg;
	reg         tdo_reg;
	reg         tdo_oe_reg;
	reg  [31:0] rd_mux;
	reg         rd_hit;

	wire        tck_s;
	wire        tms_s;
	wire        tdi_s;
	wire        link_en;
	wire        tck_rise;
	wire        tck_fall;
	wire        trst_act;
	wire        ext_act;
	wire [15:0] pat_next;
	wire        pat_done;
	wire        hit_swd;
	wire        hit_jtag;
	wire        rec_hit;
	wire [1:0]  kind;
	wire        wr_en;
	wire [4:0]  afsel_wmask;

	// Chain selection decode, used by capture, shift, update and output
	function [1:0] dpm_kind;
		input [3:0] ir;
		begin
			case (ir)
				`DPM_IR_IDCODE: dpm_kind = K_ID;
				`DPM_IR_EXTEST: dpm_kind = K_HOLD;
				`DPM_IR_INTEST: dpm_kind = K_HOLD;
				4'h2, 4'h8, 4'ha, 4'hb: dpm_kind = K_DATA;
				default: dpm_kind = K_BYP;
			endcase
		end
	endfunction

	// Two-flop synchronisers for the pins: tck, tms, tdi, trst_n, ext_rst_n
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_reg <= 5'h1f;
			sync2_reg <= 5'h1f;
		end
		else
		begin
			sync1_reg <= {ext_rst_n, trst_n, tdi, tms, tck};
			sync2_reg <= sync1_reg;
		end
	end

	assign tck_s    = sync2_reg[0];
	assign tms_s    = sync2_reg[1];
	assign tdi_s    = sync2_reg[2];
	// With the clock or mode-select pin released the probe is unheard until their select bits return
	assign link_en  = afsel_reg[`DPM_PIN_TCK] & afsel_reg[`DPM_PIN_TMS];
	assign tck_rise = link_en & tck_s & ~tck_prev_reg;
	assign tck_fall = link_en & ~tck_s & tck_prev_reg;
	assign trst_act = ~sync2_reg[3] & afsel_reg[`DPM_PIN_TRST];
	assign ext_act  = ~sync2_reg[4];

	// Edge history of the test clock and the external reset
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tck_prev_reg <= 1'b1;
			ext_prev_reg <= 1'b0;
		end
		else
		begin
			tck_prev_reg <= tck_s;
			ext_prev_reg <= ext_act;
		end
	end

	// Controller next state
	always @*
	begin
		case (tap_reg)
			S_TLR:  tap_next = tms_s ? S_TLR  : S_RTI;
			S_RTI:  tap_next = tms_s ? S_SDR  : S_RTI;
			S_SDR:  tap_next = tms_s ? S_SIR  : S_CDR;
			S_CDR:  tap_next = tms_s ? S_E1DR : S_SHDR;
			S_SHDR: tap_next = tms_s ? S_E1DR : S_SHDR;
			S_E1DR: tap_next = tms_s ? S_UDR  : S_PDR;
			S_PDR:  tap_next = tms_s ? S_E2DR : S_PDR;
			S_E2DR: tap_next = tms_s ? S_UDR  : S_SHDR;
			S_UDR:  tap_next = tms_s ? S_SDR  : S_RTI;
			S_SIR:  tap_next = tms_s ? S_TLR  : S_CIR;
			S_CIR:  tap_next = tms_s ? S_E1IR : S_SHIR;
			S_SHIR: tap_next = tms_s ? S_E1IR : S_SHIR;
			S_E1IR: tap_next = tms_s ? S_UIR  : S_PIR;
			S_PIR:  tap_next = tms_s ? S_E2IR : S_PIR;
			S_E2IR: tap_next = tms_s ? S_UIR  : S_SHIR;
			S_UIR:  tap_next = tms_s ? S_SDR  : S_RTI;
			default: tap_next = S_TLR;
		endcase
	end

	assign kind = dpm_kind(ir_reg);

	// Controller state, instruction and data chains, stepped on test clock rises
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tap_reg      <= S_TLR;
			ir_shift_reg <= `DPM_IR_IDCODE;
			ir_reg       <= `DPM_IR_IDCODE;
			byp_reg      <= 1'b0;
			dr_shift_reg <= 32'h0000_0000;
			dr_upd_reg   <= 32'h0000_0000;
			dr_stb_reg   <= 1'b0;
		end
		else
		begin
			dr_stb_reg <= 1'b0;
			if (trst_act || swd_reg)
			begin
				tap_reg <= S_TLR;
				ir_reg  <= `DPM_IR_IDCODE;
			end
			else if (tck_rise)
			begin
				tap_reg <= tap_next;
				case (tap_reg)
					S_TLR:  ir_reg <= `DPM_IR_IDCODE;
					S_CIR:  ir_shift_reg <= `DPM_IR_CAPTURE;
					S_SHIR: ir_shift_reg <= {tdi_s, ir_shift_reg[3:1]};
					S_UIR:  ir_reg <= ir_shift_reg;
					S_CDR:
					begin
						byp_reg <= 1'b0;
						if (kind == K_ID)
							dr_shift_reg <= IDCODE_VALUE;
						else if (kind == K_DATA)
							dr_shift_reg <= dr_capture_data;
					end
					S_SHDR:
					begin
						byp_reg <= tdi_s;
						if (kind == K_ID || kind == K_DATA)
							dr_shift_reg <= {tdi_s, dr_shift_reg[31:1]};
					end
					S_UDR:
					begin
						if (kind == K_DATA)
						begin
							dr_upd_reg <= dr_shift_reg;
							dr_stb_reg <= 1'b1;
						end
					end
					default: ;
				endcase
			end
		end
	end

	// Output data changes on the falling test clock; driven only while shifting
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tdo_reg    <= 1'b1;
			tdo_oe_reg <= 1'b0;
		end
		else if (tck_fall || swd_reg || trst_act)
		begin
			if (tap_reg == S_SHIR)
				tdo_reg <= ir_shift_reg[0];
			else if (tap_reg == S_SHDR)
				tdo_reg <= (kind == K_ID || kind == K_DATA) ? dr_shift_reg[0] : byp_reg;
			tdo_oe_reg <= (tap_reg == S_SHIR || tap_reg == S_SHDR) && !swd_reg && !trst_act;
		end
	end

	// Mode switch detector: 16 bits, LSB first, after a run of ones
	assign pat_next = {tms_s, pat_reg[15:1]};
	assign pat_done = tck_rise && (coll_reg == `DPM_PAT_LAST);
	assign hit_swd  = pat_done && (pat_next == `DPM_PAT_TO_SWD);
	assign hit_jtag = pat_done && long_reg && (pat_next == `DPM_PAT_TO_JTAG);
	assign rec_hit  = rec_cnt_reg[0] ? hit_jtag : hit_swd;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			run_reg      <= 6'h00;
			coll_reg     <= 5'h00;
			pat_reg      <= 16'h0000;
			long_reg     <= 1'b0;
			swd_reg      <= 1'b0;
			line_rst_reg <= 1'b0;
		end
		else
		begin
			line_rst_reg <= 1'b0;
			if (tck_rise)
			begin
				// Saturating count of consecutive ones
				if (!tms_s)
					run_reg <= 6'h00;
				else if (run_reg != `DPM_RUN_MIN)
				begin
					run_reg <= run_reg + 6'h01;
					if (swd_reg && run_reg == `DPM_RUN_MIN - 6'h01)
						line_rst_reg <= 1'b1;
				end
				if (coll_reg != 5'h00)
				begin
					pat_reg  <= pat_next;
					coll_reg <= pat_done ? 5'h00 : coll_reg + 5'h01;
				end
				else if (!tms_s && (run_reg == `DPM_RUN_MIN || (!swd_reg && tap_reg == S_TLR)))
				begin
					pat_reg  <= pat_next;
					coll_reg <= 5'h01;
					long_reg <= (run_reg == `DPM_RUN_MIN);
				end
			end
			if (hit_swd)
				swd_reg <= 1'b1;
			else if (hit_jtag)
				swd_reg <= 1'b0;
		end
	end

	// Recovery: count alternating switches while external reset is held
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rec_cnt_reg <= 4'h0;
			erase_reg   <= 1'b0;
		end
		else
		begin
			erase_reg <= ext_prev_reg && !ext_act && (rec_cnt_reg == `DPM_RECOVER_COUNT);
			if (!ext_act)
				rec_cnt_reg <= 4'h0;
			else if (rec_hit && rec_cnt_reg != `DPM_RECOVER_COUNT)
				rec_cnt_reg <= rec_cnt_reg + 4'h1;
		end
	end

	// Bus write path; protected bits need unlock and commit
	assign wr_en       = psel && penable && pwrite;
	assign afsel_wmask = ~`DPM_PROT_MASK | (commit_reg & {5{~locked_reg}});

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			afsel_reg  <= `DPM_AFSEL_RST;
			den_reg    <= `DPM_DEN_RST;
			pur_reg    <= `DPM_PUR_RST;
			commit_reg <= `DPM_COMMIT_RST;
			locked_reg <= 1'b1;
		end
		else if (ext_act)
		begin
			afsel_reg  <= `DPM_AFSEL_RST;
			den_reg    <= `DPM_DEN_RST;
			pur_reg    <= `DPM_PUR_RST;
			commit_reg <= `DPM_COMMIT_RST;
			locked_reg <= 1'b1;
		end
		else if (wr_en)
		begin
			case (paddr)
				`DPM_OFF_AFSEL:  afsel_reg <= (afsel_reg & ~afsel_wmask) | (pwdata[4:0] & afsel_wmask);
				`DPM_OFF_DEN:    den_reg <= pwdata[4:0];
				`DPM_OFF_PUR:    pur_reg <= pwdata[4:0];
				`DPM_OFF_LOCK:   locked_reg <= (pwdata != LOCK_KEY);
				`DPM_OFF_COMMIT:
				begin
					if (!locked_reg)
						commit_reg <= pwdata[4:0];
				end
				default: ;
			endcase
		end
	end

	// Read decode; chains and instruction stay off the bus
	always @*
	begin
		rd_hit = 1'b1;
		case (paddr)
			`DPM_OFF_AFSEL:  rd_mux = {27'h0, afsel_reg};
			`DPM_OFF_DEN:    rd_mux = {27'h0, den_reg};
			`DPM_OFF_PUR:    rd_mux = {27'h0, pur_reg};
			`DPM_OFF_LOCK:   rd_mux = {31'h0, locked_reg};
			`DPM_OFF_COMMIT: rd_mux = {27'h0, commit_reg};
			`DPM_OFF_STATUS: rd_mux = {tap_reg, 11'h0, rec_cnt_reg, swd_reg};
			default:
			begin
				rd_mux = 32'h0000_0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	// Read data captured in the setup cycle
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_reg <= 32'h0000_0000;
		else if (psel && !penable)
			prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
	end

	// Outputs
	assign prdata                        = prdata_reg;
	assign pready                        = 1'b1;
	assign pslverr                       = psel && penable && !rd_hit;
	assign tdo                           = tdo_reg;
	assign tdo_oe                        = tdo_oe_reg & afsel_reg[`DPM_PIN_TDO];
	assign dr_update_data                = dr_upd_reg;
	assign dr_update_strobe              = dr_stb_reg;
	assign ir_current                    = ir_reg;
	assign swd_mode                      = swd_reg;
	assign swd_line_reset                = line_rst_reg;
	assign mass_erase_req                = erase_reg;
	assign pin_digital_enable            = den_reg;
	assign pin_pullup_enable             = pur_reg;
	assign pin_alternate_function_select = afsel_reg;

endmodule

// >>> tb/dpm_checker.sv
// Assertion checker for the debug port mode switch block
`timescale 1ns/1ps
module dpm_checker
(
	input wire        pclk,
	input wire        presetn,
	input wire [11:0] paddr,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire        pslverr,
	input wire        ext_rst_n,
	input wire        tck,
	input wire        trst_n,
	input wire        tdo_oe,
	input wire [31:0] dr_update_data,
	input wire        dr_update_strobe,
	input wire [3:0]  ir_current,
	input wire        swd_mode,
	input wire        swd_line_reset,
	input wire        mass_erase_req,
	input wire [4:0]  pin_digital_enable,
	input wire [4:0]  pin_pullup_enable,
	input wire [4:0]  pin_alternate_function_select
);
	reg [3:0] ext_cnt_reg;
	reg [3:0] tck_cnt_reg;

	// Cycles since external reset was low, and since test clock moved or test reset was low
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ext_cnt_reg <= 4'h0;
			tck_cnt_reg <= 4'hf;
		end
		else
		begin
			ext_cnt_reg <= !ext_rst_n ? 4'h0 : ext_cnt_reg + {3'h0, ext_cnt_reg != 4'hf};
			tck_cnt_reg <= ($changed(tck) || !trst_n) ? 4'h0 : tck_cnt_reg + {3'h0, tck_cnt_reg != 4'hf};
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// External reset held long enough to pass the synchroniser
	sequence ext_held;
		!ext_rst_n [*5];
	endsequence
	// Erase request lasts exactly one cycle
	sequence erase_pulse;
		mass_erase_req ##1 !mass_erase_req;
	endsequence

	pin_default_a: assert property (ext_held |-> pin_digital_enable == 5'h1f &&
		pin_pullup_enable == 5'h1f && pin_alternate_function_select == 5'h1f)
		else $error("pin defaults not restored");
	afsel_cause_a: assert property ($changed(pin_alternate_function_select) |->
		$past(psel && penable && pwrite && paddr == 12'h000) || ext_cnt_reg < 4'h5)
		else $error("select bits changed without cause");
	unmapped_err_a: assert property (psel && penable && paddr > 12'h014 |-> pslverr)
		else $error("unmapped access not refused");
	ir_serial_a: assert property ($changed(ir_current) |-> tck_cnt_reg < 4'h8)
		else $error("instruction changed without test clock");
	erase_window_a: assert property (mass_erase_req |-> ext_cnt_reg inside {[4'h1:4'ha]})
		else $error("erase request outside reset release");
	erase_once_a: assert property (mass_erase_req |-> erase_pulse)
		else $error("erase request too long");
	line_reset_a: assert property (swd_line_reset |-> swd_mode)
		else $error("line reset outside serial-wire mode");
	strobe_data_a: assert property ($changed(dr_update_data) |->
		dr_update_strobe || $past(dr_update_strobe))
		else $error("update data changed without strobe");
	swd_idle_tap_a: assert property (swd_mode |-> ir_current == 4'he && !tdo_oe)
		else $error("boundary-test side active in serial-wire mode");
endmodule

bind dpm_debug_port dpm_checker chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pslverr(pslverr), .ext_rst_n(ext_rst_n), .tck(tck),
	.trst_n(trst_n), .tdo_oe(tdo_oe), .dr_update_data(dr_update_data), .dr_update_strobe(dr_update_strobe),
	.ir_current(ir_current), .swd_mode(swd_mode), .swd_line_reset(swd_line_reset),
	.mass_erase_req(mass_erase_req), .pin_digital_enable(pin_digital_enable),
	.pin_pullup_enable(pin_pullup_enable), .pin_alternate_function_select(pin_alternate_function_select));

// >>> tb/dpm_probe.sv
// Debug probe model driving test clock, mode select and test data
`timescale 1ns/1ps
module dpm_probe
(
	output logic tck,
	output logic tms,
	output logic tdi,
	input  wire  tdo
);
	logic [63:0] cap;

	// Clock stands low between frames, mode select rests at its pull-up level
	initial
	begin
		tck = 1'h0;
		tms = 1'h1;
		tdi = 1'h1;
	end

	// One frame, lines change while the clock is low, output sampled before each rise
	task automatic frame(input int n, input logic [63:0] tv, input logic [63:0] dv);
		for (int i = 0; i < n; i++)
		begin
			tms = tv[i];
			tdi = dv[i];
			#62.5;
			cap[i] = tdo;
			tck = 1'h1;
			#62.5;
			tck = 1'h0;
		end
		tms = 1'h1;
		tdi = ~tdi;
	endtask
endmodule

// >>> tb/dpm_debug_port_bench.sv
// Self-checking bench for the debug port mode switch block
`timescale 1ns/1ps
module dpm_debug_port_bench;
	localparam [31:0] KEY = 32'h6b1d_52a7;
	localparam [31:0] CAP = 32'h5a3c_96e1;
	logic        pclk, presetn, psel, penable, pwrite, ext_rst_n, trst_n, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, rd;
	logic [31:0] n_lr = 32'h0, n_er = 32'h0, n_st = 32'h0;
	wire  [31:0] prdata, upd;
	wire         pready, pslverr, tck, tms, tdi, tdo, tdo_oe, strobe, swd, lrst, erase;
	wire  [3:0]  ir;
	wire  [4:0]  den, pur, afs;
	int          mismatches, tests_run, cyc;
	logic [44:0] rows [7] = '{{12'h000, 32'h1f, 1'h0}, {12'h004, 32'h1f, 1'h0}, {12'h008, 32'h1f, 1'h0},
		{12'h00c, 32'h1, 1'h0}, {12'h010, 32'h0, 1'h0}, {12'h014, 32'h0001_0000, 1'h0}, {12'h018, 32'h0, 1'h1}};

	dpm_debug_port #(.LOCK_KEY(KEY)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_rst_n(ext_rst_n), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
		.tdo(tdo), .tdo_oe(tdo_oe), .dr_capture_data(CAP), .dr_update_data(upd), .dr_update_strobe(strobe),
		.ir_current(ir), .swd_mode(swd), .swd_line_reset(lrst), .mass_erase_req(erase),
		.pin_digital_enable(den), .pin_pullup_enable(pur), .pin_alternate_function_select(afs));
	dpm_probe pr (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

	// System clock
	initial
	begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end

	// Pulse counters and run limit
	always @(posedge pclk)
	begin
		cyc++;
		n_lr <= n_lr + {31'h0, lrst === 1'h1};
		n_er <= n_er + {31'h0, erase === 1'h1};
		n_st <= n_st + {31'h0, strobe === 1'h1};
		if (cyc == 40000)
		begin
			mismatches++;
			print_verdict;
		end
	end

	task print_verdict;
		$display("Checks %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One register transfer, waits for pready before release
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// Ends at the first edge that sees pready high
		do
			@(posedge pclk);
		while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task wait_clk(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task ones(input int n);
		pr.frame(n, '1, 64'h0);
	endtask

	// From test-logic-reset: load an instruction, end in idle
	task ir_load(input logic [3:0] v);
		pr.frame(11, 64'h306, {55'h0, v, 5'h0});
		wait_clk(8);
	endtask

	initial
	begin
		{presetn, psel, penable, pwrite, ext_rst_n, trst_n} = 6'h03;
		paddr = 12'h0;
		pwdata = 32'h0;
		wait_clk(6);
		presetn <= 1'h1;
		wait_clk(3);
		// Reset values and refusal of unmapped place
		foreach (rows[i])
		begin
			apb(1'h0, rows[i][44:33], 32'h0);
			chk("read", rows[i][32:1], rd);
			chk("error", {31'h0, rows[i][0]}, {31'h0, er});
		end
		// Instruction then data scan
		ir_load(4'h2);
		chk("ir capture", 32'h1, {28'h0, pr.cap[8:5]});
		chk("ir", 32'h2, {28'h0, ir});
		pr.frame(37, 64'hc_0000_0001, {29'h0, 32'hc3a5_0f96, 3'h0});
		wait_clk(8);
		chk("dr out", CAP, pr.cap[34:3]);
		chk("dr update", 32'hc3a5_0f96, upd);
		chk("strobes", 32'h1, n_st);
		chk("oe idle", 32'h0, {31'h0, tdo_oe});
		ones(5);
		wait_clk(8);
		chk("ir reset", 32'he, {28'h0, ir});
		// Mode switches both ways
		ones(50);
		pr.frame(16, 64'he79e, 64'h0);
		wait_clk(8);
		chk("to swd", 32'h1, {31'h0, swd});
		ones(50);
		wait_clk(8);
		chk("line reset", 32'h1, n_lr);
		pr.frame(16, 64'he73c, 64'h0);
		ones(5);
		apb(1'h0, 12'h014, 32'h0);
		chk("status", 32'h0001_0000, rd);
		pr.frame(16, 64'he79e, 64'h0);
		wait_clk(8);
		chk("path swd", 32'h1, {31'h0, swd});
		ones(50);
		pr.frame(16, 64'he73c, 64'h0);
		// Recovery under held external reset
		wait_clk(1);
		ext_rst_n <= 1'h0;
		for (int i = 0; i < 10; i++)
		begin
			ones(50);
			pr.frame(16, i[0] ? 64'he73c : 64'he79e, 64'h0);
		end
		wait_clk(2);
		ext_rst_n <= 1'h1;
		wait_clk(10);
		chk("erase", 32'h1, n_er);
		ones(5);
		// Pin hand-over under lock and commit
		apb(1'h1, 12'h000, 32'h0);
		wait_clk(1);
		chk("locked afsel", 32'h1f, {27'h0, afs});
		apb(1'h1, 12'h00c, KEY);
		apb(1'h1, 12'h010, 32'h1f);
		apb(1'h1, 12'h000, 32'h0);
		wait_clk(1);
		chk("afsel", 32'h0, {27'h0, afs});
		ir_load(4'hf);
		chk("released", 32'he, {28'h0, ir});
		apb(1'h1, 12'h000, 32'h1f);
		ir_load(4'hf);
		chk("restored", 32'hf, {28'h0, ir});
		trst_n <= 1'h0;
		wait_clk(10);
		trst_n <= 1'h1;
		chk("test reset", 32'he, {28'h0, ir});
		// External reset restores released and cleared pin fields
		apb(1'h1, 12'h004, 32'h0);
		apb(1'h1, 12'h008, 32'h0);
		apb(1'h1, 12'h000, 32'h0);
		wait_clk(1);
		chk("den cleared", 32'h0, {27'h0, den});
		chk("pur cleared", 32'h0, {27'h0, pur});
		chk("afsel cleared", 32'h0, {27'h0, afs});
		ext_rst_n <= 1'h0;
		wait_clk(6);
		ext_rst_n <= 1'h1;
		wait_clk(6);
		chk("ext den", 32'h1f, {27'h0, den});
		chk("ext pur", 32'h1f, {27'h0, pur});
		chk("ext afsel", 32'h1f, {27'h0, afs});
		chk("no erase", 32'h1, n_er);
		apb(1'h0, 12'h00c, 32'h0);
		chk("relock", 32'h1, rd);
		print_verdict;
	end
endmodule
